// [hw/stg_target.sv]
// Serial bus target front end with timeout, busy and hold guards
`timescale 1ns/10ps
`default_nettype none
module stg_target
  import stg_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYCLES = TIMEOUT_CYC,
  parameter int unsigned PROG_CYCLES    = PROG_CYC,
  parameter int unsigned PWRUP_CYCLES   = PWRUP_CYC
) (
  input  wire logic       i_mclk,
  input  wire logic       i_reset_n,
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  input  wire logic       i_timeout_en,
  input  wire logic [6:0] i_target_addr,
  input  wire logic [7:0] i_rd_data,
  output var  logic       o_sda_oe_n,
  output var  logic       o_sda_out,
  output var  logic       o_wr_strobe,
  output var  logic [7:0] o_wr_data,
  output var  logic       o_wr_commit,
  output var  logic       o_rd_strobe,
  output var  logic       o_busy,
  output var  logic       o_ready,
  output var  logic       o_timeout
);
  stg_pins_if pins ();

  stg_glitch_filter u_filt (
    .i_mclk    (i_mclk),
    .i_reset_n (i_reset_n),
    .i_scl     (i_scl),
    .i_sda     (i_sda),
    .pins      (pins.filt)
  );

  stg_state_t       state_reg;
  logic             scl_d_reg;
  logic             sda_d_reg;
  logic [3:0]       bit_cnt_reg;
  logic [7:0]       shift_reg;
  logic             rnw_reg;
  logic             wrote_reg;
  logic [CNT_W-1:0] low_cnt_reg;
  logic [CNT_W-1:0] prog_cnt_reg;
  logic [CNT_W-1:0] pwr_cnt_reg;
  logic [3:0]       hold_cnt_reg;
  logic             drive_low_reg;
  logic             drive_low_next;
  logic             to_hit;

  wire scl_rise = pins.scl & ~scl_d_reg;
  wire scl_fall = ~pins.scl & scl_d_reg;
  wire start_c  = pins.scl & scl_d_reg & sda_d_reg & ~pins.sda;
  wire stop_c   = pins.scl & scl_d_reg & ~sda_d_reg & pins.sda;
  wire blocked  = o_busy | ~o_ready;

  assign to_hit = i_timeout_en && !pins.scl &&
                  (low_cnt_reg >= CNT_W'(TIMEOUT_CYCLES - 1));

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= pins.scl;
      sda_d_reg <= pins.sda;
    end
  end

  // Clock-low timer; counts only while the clock is low and the timeout is enabled
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      low_cnt_reg <= '0;
      o_timeout   <= 1'b0;
    end else begin
      o_timeout <= to_hit;
      if (pins.scl || !i_timeout_en || to_hit) begin
        low_cnt_reg <= '0;
      end else begin
        low_cnt_reg <= low_cnt_reg + CNT_W'(1);
      end
    end
  end

  // Power-up guard before the bus is served
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pwr_cnt_reg <= '0;
      o_ready     <= 1'b0;
    end else if (!o_ready) begin
      pwr_cnt_reg <= pwr_cnt_reg + CNT_W'(1);
      o_ready     <= (pwr_cnt_reg >= CNT_W'(PWRUP_CYCLES - 1));
    end
  end

  // Internal programming period after a write ends with stop
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      prog_cnt_reg <= '0;
      o_busy       <= 1'b0;
      o_wr_commit  <= 1'b0;
    end else begin
      o_wr_commit <= 1'b0;
      if (o_busy) begin
        prog_cnt_reg <= prog_cnt_reg + CNT_W'(1);
        if (prog_cnt_reg >= CNT_W'(PROG_CYCLES - 1)) begin
          o_busy <= 1'b0;
        end
      end else if (stop_c && wrote_reg && !to_hit) begin
        prog_cnt_reg <= '0;
        o_busy       <= 1'b1;
        o_wr_commit  <= 1'b1;
      end
    end
  end

  // Protocol engine
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_reg   <= STG_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg   <= 8'h00;
      rnw_reg     <= 1'b0;
      wrote_reg   <= 1'b0;
      o_wr_strobe <= 1'b0;
      o_wr_data   <= 8'h00;
      o_rd_strobe <= 1'b0;
    end else begin
      o_wr_strobe <= 1'b0;
      o_rd_strobe <= 1'b0;
      if (to_hit) begin
        state_reg <= STG_IDLE;
        wrote_reg <= 1'b0;
      end else if (start_c) begin
        state_reg   <= blocked ? STG_SKIP : STG_ADDR;
        bit_cnt_reg <= 4'h0;
        wrote_reg   <= 1'b0;
      end else if (stop_c) begin
        state_reg <= STG_IDLE;
        wrote_reg <= 1'b0;
      end else if (scl_rise) begin
        unique case (state_reg)
          STG_ADDR, STG_WDATA: begin
            shift_reg   <= {shift_reg[6:0], pins.sda};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end
          STG_RDATA: begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end
          STG_RACK: begin
            // Acknowledged read reloads at the next fall via the ACK step
            state_reg <= pins.sda ? STG_SKIP : STG_ACK;
          end
          default: begin
          end
        endcase
      end else if (scl_fall) begin
        unique case (state_reg)
          STG_ADDR: begin
            if (bit_cnt_reg == 4'h8) begin
              if (shift_reg[7:1] == i_target_addr && !blocked) begin
                state_reg <= STG_ACK;
                rnw_reg   <= shift_reg[0];
              end else begin
                state_reg <= STG_SKIP;
              end
            end
          end
          STG_WDATA: begin
            if (bit_cnt_reg == 4'h8) begin
              state_reg   <= STG_ACK;
              o_wr_strobe <= 1'b1;
              o_wr_data   <= shift_reg;
              wrote_reg   <= 1'b1;
            end
          end
          STG_ACK: begin
            bit_cnt_reg <= 4'h0;
            state_reg   <= rnw_reg ? STG_RDATA : STG_WDATA;
            if (rnw_reg) begin
              shift_reg   <= i_rd_data;
              o_rd_strobe <= 1'b1;
            end
          end
          STG_RDATA: begin
            if (bit_cnt_reg == 4'h8) begin
              state_reg <= STG_RACK;
            end else begin
              shift_reg <= {shift_reg[6:0], 1'b1};
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  always_comb begin
    unique case (state_reg)
      STG_ACK:   drive_low_next = 1'b1;
      STG_RDATA: drive_low_next = ~shift_reg[7];
      default:   drive_low_next = 1'b0;
    endcase
    if (blocked && state_reg != STG_ACK) begin
      drive_low_next = 1'b0;
    end
  end

  // Drive changes wait the hold time after the clock falls; timeout or busy drops the drive at once
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      hold_cnt_reg  <= 4'h0;
      drive_low_reg <= 1'b0;
    end else if (to_hit || o_busy) begin
      hold_cnt_reg  <= 4'h0;
      drive_low_reg <= 1'b0;
    end else if (scl_fall) begin
      hold_cnt_reg <= 4'h1;
    end else if (hold_cnt_reg != 4'h0) begin
      if (hold_cnt_reg >= 4'(HOLD_CYC)) begin
        hold_cnt_reg  <= 4'h0;
        drive_low_reg <= drive_low_next;
      end else begin
        hold_cnt_reg <= hold_cnt_reg + 4'h1;
      end
    end else if (state_reg == STG_IDLE || state_reg == STG_SKIP) begin
      drive_low_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_sda_oe_n <= 1'b1;
      o_sda_out  <= 1'b0;
    end else begin
      o_sda_oe_n <= ~drive_low_reg;
      o_sda_out  <= 1'b0;
    end
  end
endmodule : stg_target
`default_nettype wire

// [inc/stg_pkg.sv]
// Package of constants and types for the serial target timing guard
package stg_pkg;
  localparam int unsigned CLK_HZ          = 25000000;
  localparam int unsigned CLK_NS          = 40;
  // Clock-low timeout window, milliseconds
  localparam int unsigned TIMEOUT_MIN_MS  = 25;
  localparam int unsigned TIMEOUT_MAX_MS  = 35;
  // Aim at the middle of the window
  localparam int unsigned TIMEOUT_MS      = 30;
  localparam int unsigned TIMEOUT_CYC     = TIMEOUT_MS * (CLK_HZ / 1000);
  // Internal programming time, milliseconds
  localparam int unsigned PROG_MS         = 10;
  localparam int unsigned PROG_CYC        = PROG_MS * (CLK_HZ / 1000);
  // Power-up delay before accesses, milliseconds
  localparam int unsigned PWRUP_MS        = 1;
  localparam int unsigned PWRUP_CYC       = PWRUP_MS * (CLK_HZ / 1000);
  // Spike width to suppress, nanoseconds
  localparam int unsigned SPIKE_NS        = 50;
  localparam int unsigned SPIKE_CYC       = (SPIKE_NS + CLK_NS - 1) / CLK_NS;
  // Internal SDA hold after SCL falls, nanoseconds
  localparam int unsigned HOLD_NS         = 200;
  localparam int unsigned HOLD_CYC        = (HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [6:0]  TARGET_ADDR_RST = 7'h50;
  localparam int unsigned CNT_W           = 20;
  typedef enum logic [2:0] {
    STG_IDLE, STG_ADDR, STG_ACK, STG_WDATA, STG_RDATA, STG_RACK, STG_SKIP
  } stg_state_t;
endpackage : stg_pkg

// [inc/stg_pins_if.sv]
// Interface carrying filtered bus levels between filter and core
`timescale 1ns/10ps
`default_nettype none
interface stg_pins_if;
  logic scl;
  logic sda;
  modport filt (output scl, output sda);
  modport core (input scl, input sda);
endinterface : stg_pins_if
`default_nettype wire

// [hw/stg_glitch_filter.sv]
// Two-stage synchroniser and spike filter for the bus inputs
`timescale 1ns/10ps
`default_nettype none
module stg_glitch_filter
  import stg_pkg::*;
(
  input  wire logic  i_mclk,
  input  wire logic  i_reset_n,
  input  wire logic  i_scl,
  input  wire logic  i_sda,
  stg_pins_if.filt   pins
);
  logic [1:0] scl_sync_reg;
  logic [1:0] sda_sync_reg;
  logic [2:0] scl_cnt_reg;
  logic [2:0] sda_cnt_reg;
  localparam logic [2:0] FCNT = 3'(SPIKE_CYC);

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], i_scl};
      sda_sync_reg <= {sda_sync_reg[0], i_sda};
    end
  end

  // A level must persist beyond the spike width before it is accepted
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      scl_cnt_reg <= 3'h0;
      pins.scl    <= 1'b1;
    end else if (scl_sync_reg[1] == pins.scl) begin
      scl_cnt_reg <= 3'h0;
    end else if (scl_cnt_reg >= FCNT) begin
      scl_cnt_reg <= 3'h0;
      pins.scl    <= scl_sync_reg[1];
    end else begin
      scl_cnt_reg <= scl_cnt_reg + 3'h1;
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sda_cnt_reg <= 3'h0;
      pins.sda    <= 1'b1;
    end else if (sda_sync_reg[1] == pins.sda) begin
      sda_cnt_reg <= 3'h0;
    end else if (sda_cnt_reg >= FCNT) begin
      sda_cnt_reg <= 3'h0;
      pins.sda    <= sda_sync_reg[1];
    end else begin
      sda_cnt_reg <= sda_cnt_reg + 3'h1;
    end
  end
endmodule : stg_glitch_filter
`default_nettype wire

// [test/stg_target_asserts.sv]
// Checker of the target's timing guards
`timescale 1ns/10ps
`default_nettype none
module stg_target_asserts
  import stg_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYCLES = TIMEOUT_CYC,
  parameter int unsigned PROG_CYCLES    = PROG_CYC
) (
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire logic i_scl,
  input wire logic i_timeout_en,
  input wire logic o_sda_oe_n,
  input wire logic o_wr_strobe,
  input wire logic o_wr_commit,
  input wire logic o_rd_strobe,
  input wire logic o_busy,
  input wire logic o_ready,
  input wire logic o_timeout
);
  int busy_cnt_reg;
  int low_cnt_reg;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) busy_cnt_reg <= 0;
    else busy_cnt_reg <= o_busy ? busy_cnt_reg + 1 : 0;
  end
  // Raw clock-low time, which is also the time since the last fall
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) low_cnt_reg <= 0;
    else low_cnt_reg <= i_scl ? 0 : low_cnt_reg + 1;
  end
  sequence s_prog_run;
    o_busy [*8];
  endsequence
  sequence s_quiet;
    (o_sda_oe_n && !o_wr_commit) [*8];
  endsequence
  chk_busy_release: assert property (o_busy |-> o_sda_oe_n)
    else $error("data line driven while busy");
  chk_busy_no_take: assert property
    (o_busy |-> !o_wr_strobe && !o_rd_strobe)
    else $error("transfer taken while busy");
  chk_early_release: assert property (!o_ready |-> o_sda_oe_n)
    else $error("data line driven before ready");
  chk_commit_busy: assert property
    (o_wr_commit |-> ##[0:1] s_prog_run)
    else $error("programming did not follow commit");
  chk_prog_bound: assert property
    (o_busy |-> busy_cnt_reg < PROG_CYCLES)
    else $error("programming too long");
  chk_timeout_win: assert property (o_timeout |-> i_timeout_en &&
    low_cnt_reg >= TIMEOUT_CYCLES && low_cnt_reg <= TIMEOUT_CYCLES + 16)
    else $error("timeout outside its window");
  chk_timeout_quiet: assert property (o_timeout |=> s_quiet)
    else $error("bus not idle after timeout");
  chk_timeout_off: assert property
    (!i_timeout_en && !$past(i_timeout_en, 8) |-> !o_timeout)
    else $error("timeout while disabled");
  chk_hold_delay: assert property
    ($fell(o_sda_oe_n) |-> !i_scl && low_cnt_reg >= HOLD_CYC)
    else $error("data drive too soon after clock fall");
endmodule : stg_target_asserts
bind stg_target stg_target_asserts #(
  .TIMEOUT_CYCLES(TIMEOUT_CYCLES), .PROG_CYCLES(PROG_CYCLES)) i_chk (
  .i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_scl(i_scl),
  .i_timeout_en(i_timeout_en), .o_sda_oe_n(o_sda_oe_n),
  .o_wr_strobe(o_wr_strobe), .o_wr_commit(o_wr_commit),
  .o_rd_strobe(o_rd_strobe), .o_busy(o_busy), .o_ready(o_ready),
  .o_timeout(o_timeout));
`default_nettype wire

// [test/stg_host_model.sv]
// Behavioural bus host driving the clock and pulling the data line
`timescale 1ns/10ps
`default_nettype none
module stg_host_model (
  input  wire logic i_mclk,
  input  wire logic i_sda,
  output var  logic o_scl,
  output var  logic o_sda_low
);
  logic glitch = 1'b0;
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n * 8) @(negedge i_mclk);
  endtask : tick
  task automatic start_c();
    o_sda_low = 1'b1;
    tick(1);
    o_scl = 1'b0;
    tick(1);
  endtask : start_c
  task automatic stop_c();
    o_sda_low = 1'b1;
    tick(1);
    o_scl = 1'b1;
    tick(1);
    o_sda_low = 1'b0;
    tick(1);
  endtask : stop_c
  // Low phase kept short, far below the clock-low timeout
  task automatic bit_c(input logic b, output logic r);
    o_sda_low = !b;
    tick(1);
    o_scl = 1'b1;
    tick(1);
    r = i_sda;
    if (glitch) begin
      o_sda_low = b;
      @(negedge i_mclk);
      o_sda_low = !b;
    end
    tick(1);
    o_scl = 1'b0;
    tick(1);
  endtask : bit_c
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_c(d[i], r);
    bit_c(1'b1, r);
    ack = !r;
  endtask : put_byte
  task automatic get_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_c(1'b1, d[i]);
    bit_c(last, r);
  endtask : get_byte
endmodule : stg_host_model
`default_nettype wire

// [test/tb.sv]
// Self-checking bench for the serial target timing guard
`timescale 1ns/10ps
`default_nettype none
module tb;
  import stg_pkg::*;
  localparam int PRC = 600;
  logic mclk, rst_n, scl, host_low, sda, to_en, busy, ready;
  logic sda_oe_n, sda_out, wr_strobe, wr_commit, rd_strobe, tmo;
  logic [7:0] rd_data, wr_data;
  logic [6:0] addr;
  logic [11:0] exp_q[$];
  int n_mismatch = 0;
  int checked = 0;
  int seed = 61;
  assign sda = !host_low && (sda_oe_n || sda_out);
  stg_target #(.TIMEOUT_CYCLES(200), .PROG_CYCLES(PRC)) i_dut (
    .i_mclk(mclk), .i_reset_n(rst_n), .i_scl(scl), .i_sda(sda),
    .i_timeout_en(to_en), .i_target_addr(addr),
    .i_rd_data(rd_data), .o_sda_oe_n(sda_oe_n), .o_sda_out(sda_out),
    .o_wr_strobe(wr_strobe), .o_wr_data(wr_data), .o_wr_commit(wr_commit),
    .o_rd_strobe(rd_strobe), .o_busy(busy), .o_ready(ready),
    .o_timeout(tmo));
  stg_host_model i_host (.i_mclk(mclk), .i_sda(sda), .o_scl(scl),
    .o_sda_low(host_low));
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  task automatic fail(input string m);
    n_mismatch++;
    $display("[ERR] %0t %s", $time, m);
  endtask : fail
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : tally_and_finish
  task automatic check_val(input logic [7:0] got, exp, input string m);
    checked++;
    if (got !== exp) fail(m);
  endtask : check_val
  task automatic check_evt(input logic [11:0] e);
    checked++;
    if ({wr_strobe, wr_commit, tmo, rd_strobe,
         wr_strobe ? wr_data : 8'h00} !== e) fail("event mismatch");
  endtask : check_evt
  task automatic wait_level(ref logic s, input logic v, input int lim);
    for (int k = 0; k < lim && s !== v; k++) @(negedge mclk);
    if (s !== v) begin
      fail("wait ran out");
      tally_and_finish();
    end
  endtask : wait_level
  task automatic send(input logic [7:0] b, input logic exp);
    logic a;
    i_host.put_byte(b, a);
    check_val({7'h00, a}, {7'h00, exp}, "acknowledge");
  endtask : send
  task automatic send_data(input logic [7:0] d);
    exp_q.push_back({4'b1000, d});
    send(d, 1'b1);
  endtask : send_data
  // Outputs are settled at the falling edge
  always @(negedge mclk) begin
    if (rst_n && (wr_strobe || wr_commit || tmo || rd_strobe)) begin
      if (exp_q.size() == 0) fail("unexpected event");
      else check_evt(exp_q.pop_front());
    end
  end
  initial begin
    logic [7:0] d;
    logic r;
    rst_n = 1'b0;
    to_en = 1'b1;
    rd_data = 8'h00;
    addr = 7'($random(seed));
    repeat (12) @(negedge mclk);
    rst_n = 1'b1;
    check_val({7'h00, ready}, 8'h00, "ready too early");
    repeat (PWRUP_CYC - 1) @(negedge mclk);
    check_val({7'h00, ready}, 8'h00, "ready before delay");
    wait_level(ready, 1'b1, 4);
    i_host.glitch = 1'b1;
    i_host.start_c();
    send({addr, 1'b0}, 1'b1);
    for (int i = 0; i < 2; i++) send_data(8'($random(seed)));
    i_host.glitch = 1'b0;
    exp_q.push_back(12'h400);
    i_host.stop_c();
    i_host.start_c();
    send({addr, 1'b0}, 1'b0);
    i_host.stop_c();
    check_val({7'h00, busy}, 8'h01, "refusal not while busy");
    wait_level(busy, 1'b0, PRC);
    rd_data = 8'($random(seed));
    i_host.start_c();
    exp_q.push_back(12'h100);
    exp_q.push_back(12'h100);
    send({addr, 1'b1}, 1'b1);
    i_host.get_byte(1'b0, d);
    check_val(d, rd_data, "read data");
    i_host.get_byte(1'b1, d);
    check_val(d, rd_data, "second read data");
    i_host.stop_c();
    // Clock held low three bits into the byte after a whole data byte; that byte must not commit
    i_host.start_c();
    send({addr, 1'b0}, 1'b1);
    send_data(8'($random(seed)));
    for (int i = 0; i < 3; i++) i_host.bit_c(1'b0, r);
    exp_q.push_back(12'h200);
    i_host.tick(30);
    i_host.stop_c();
    to_en = 1'b0;
    i_host.start_c();
    send({addr, 1'b0}, 1'b1);
    i_host.tick(40);
    send_data(8'($random(seed)));
    exp_q.push_back(12'h400);
    i_host.stop_c();
    wait_level(busy, 1'b0, PRC);
    check_val(8'(exp_q.size()), 8'h00, "events missing");
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
